// [core/opc_pkg.sv]
package opc_pkg;

	// ****************************************
	// register locations
	// ****************************************
	localparam logic [7:0] ADR_MAKER_LO = 8'h00;
	localparam logic [7:0] ADR_MAKER_HI = 8'h01;
	localparam logic [7:0] ADR_PART_LO  = 8'h02;
	localparam logic [7:0] ADR_PART_HI  = 8'h03;
	localparam logic [7:0] ADR_C1_SET   = 8'h04;
	localparam logic [7:0] ADR_C1_CLR   = 8'h05;
	localparam logic [7:0] ADR_C2_SET   = 8'h06;
	localparam logic [7:0] ADR_C2_CLR   = 8'h07;

	// identity values are arbitrary
	localparam logic [15:0] MAKER_ID = 16'h1a2b;
	localparam logic [15:0] PART_ID  = 16'h3c4d;
	// serial bus address is arbitrary
	localparam logic [6:0]  BUS_ADDR = 7'h2d;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] READ_NONE  = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int C1_SPEED   = 0;
	localparam int C1_SUSPEND = 1;
	localparam int C1_FORMAT  = 2;
	localparam int C1_TEST    = 3;
	localparam int C1_ATTACH  = 4;
	localparam int C1_INT_OUT = 5;
	localparam int C1_UART    = 6;
	localparam int C1_UART_IO = 7;
	localparam int C2_DP_PU   = 0;
	localparam int C2_DM_PU   = 1;
	localparam int C2_DP_PD   = 2;
	localparam int C2_DM_PD   = 3;
	localparam int C2_ID_GND  = 4;
	localparam int C2_VB_DRV  = 5;
	localparam int C2_VB_DIS  = 6;
	localparam int C2_VB_CHG  = 7;

	// ****************************************
	// pin sampling and serial framing
	// ****************************************
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SE0 = 2;
	localparam int PIN_GP  = 3;
	localparam int NPIN    = 6;
	localparam int GP_RX   = 0;
	localparam int GP_TX   = 1;
	localparam int GP_FREE = 2;

	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT  = 4'h8;
	// the fall that follows a start comes before the first bit and wraps this to zero
	localparam logic [3:0] FIRST_FALL = 4'hf;

	typedef enum logic [2:0] {
		OPC_IDLE,
		OPC_ADDR,
		OPC_REG,
		OPC_WR,
		OPC_RD
	} opc_state_t;

endpackage

// [core/opc_regs.sv]
`timescale 1ns/1ps
module opc_regs (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// two-wire serial port
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// line sense and interrupt source
	input  wire logic       se0_in,
	input  wire logic       irq_pending_in,
	// general-purpose pins
	input  wire logic [2:0] gpio_pin_in,
	input  wire logic [2:0] gpio_out_in,
	input  wire logic [2:0] gpio_oe_in,
	input  wire logic       uart2_tx_in,
	output logic [2:0]      gpio_pin_out,
	output logic [2:0]      gpio_pin_oe,
	output logic [2:0]      gpio_level,
	output logic            uart2_rx,
	// interrupt/output-enable pin
	output logic            oe_int_n_out,
	output logic            oe_int_oe,
	// line mode controls
	output logic            full_speed,
	output logic            low_power,
	output logic            single_ended_format_select,
	output logic            uart_mode,
	output logic            se0_attach_flag,
	// bus pull and supply controls
	output logic            plus_line_pullup,
	output logic            minus_line_pullup,
	output logic            plus_line_pulldown,
	output logic            minus_line_pulldown,
	output logic            ident_pin_ground,
	output logic            vbus_drive,
	output logic            vbus_discharge,
	output logic            vbus_charge
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [opc_pkg::NPIN-1:0] pins;
	logic [opc_pkg::NPIN-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
	assign pins = {gpio_pin_in, se0_in, sda_in, scl_in};

	genvar gi;
	generate
		for (gi = 0; gi < opc_pkg::NPIN; gi++) begin : g_sync
			// a level only counts once two late stages agree, which filters glitches
			always_comb begin
				flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					s1_q[gi]  <= 1'b1;
					s2_q[gi]  <= 1'b1;
					s3_q[gi]  <= 1'b1;
					flt_q[gi] <= 1'b1;
				end else if (clk_en) begin
					s1_q[gi]  <= pins[gi];
					s2_q[gi]  <= s1_q[gi];
					s3_q[gi]  <= s2_q[gi];
					flt_q[gi] <= flt_d[gi];
				end
			end
		end
	endgenerate

	// ****************************************
	// serial slave and control registers
	// ****************************************
	opc_pkg::opc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, tx_q, tx_d, c1_q, c1_d, c2_q, c2_d;
	logic       oe_q, oe_d, nack_q, nack_d, attach_q, attach_d;
	logic       scl_prev_q, sda_prev_q;
	logic       scl_rise, scl_fall, start_c, stop_c;
	logic       wr_en;
	logic [7:0] wr_data, rd_cur, rd_next;

	function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] r1,
						input logic [7:0] r2);
		logic [7:0] v;
		v = opc_pkg::READ_NONE;
		unique case (a)
			opc_pkg::ADR_MAKER_LO: v = opc_pkg::MAKER_ID[7:0];
			opc_pkg::ADR_MAKER_HI: v = opc_pkg::MAKER_ID[15:8];
			opc_pkg::ADR_PART_LO:  v = opc_pkg::PART_ID[7:0];
			opc_pkg::ADR_PART_HI:  v = opc_pkg::PART_ID[15:8];
			opc_pkg::ADR_C1_SET, opc_pkg::ADR_C1_CLR: v = r1;
			opc_pkg::ADR_C2_SET, opc_pkg::ADR_C2_CLR: v = r2;
			default: v = opc_pkg::READ_NONE;
		endcase
		return v;
	endfunction

	assign scl_rise = flt_q[opc_pkg::PIN_SCL] & ~scl_prev_q;
	assign scl_fall = ~flt_q[opc_pkg::PIN_SCL] & scl_prev_q;
	assign start_c  = flt_q[opc_pkg::PIN_SCL] & scl_prev_q & sda_prev_q & ~flt_q[opc_pkg::PIN_SDA];
	assign stop_c   = flt_q[opc_pkg::PIN_SCL] & scl_prev_q & ~sda_prev_q & flt_q[opc_pkg::PIN_SDA];
	assign wr_data  = sh_q;
	assign rd_cur   = read_byte(ptr_q, c1_q, c2_q);
	assign rd_next  = read_byte(ptr_q + 8'h01, c1_q, c2_q);

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		ptr_d  = ptr_q;
		tx_d   = tx_q;
		oe_d   = oe_q;
		nack_d = nack_q;
		wr_en  = 1'b0;
		if (start_c) begin
			st_d  = opc_pkg::OPC_ADDR;
			// the first scl fall after a start must not count as a bit
			cnt_d = opc_pkg::FIRST_FALL;
			oe_d  = 1'b0;
		end else if (stop_c) begin
			st_d = opc_pkg::OPC_IDLE;
			oe_d = 1'b0;
		end else if (st_q != opc_pkg::OPC_IDLE) begin
			if (scl_rise) begin
				if (cnt_q == opc_pkg::ACK_BIT) begin
					nack_d = flt_q[opc_pkg::PIN_SDA];
				end else begin
					sh_d = {sh_q[6:0], flt_q[opc_pkg::PIN_SDA]};
				end
			end
			if (scl_fall) begin
				if (cnt_q == opc_pkg::LAST_BIT) begin
					cnt_d = opc_pkg::ACK_BIT;
					unique case (st_q)
						opc_pkg::OPC_ADDR: begin
							oe_d = (sh_q[7:1] == opc_pkg::BUS_ADDR);
							if (sh_q[7:1] != opc_pkg::BUS_ADDR) begin
								st_d = opc_pkg::OPC_IDLE;
							end
						end
						opc_pkg::OPC_REG: oe_d = 1'b1;
						opc_pkg::OPC_WR: begin
							oe_d  = 1'b1;
							wr_en = 1'b1;
						end
						opc_pkg::OPC_RD: oe_d = 1'b0;
						opc_pkg::OPC_IDLE: oe_d = 1'b0;
					endcase
				end else if (cnt_q == opc_pkg::ACK_BIT) begin
					cnt_d = 4'h0;
					oe_d  = 1'b0;
					unique case (st_q)
						opc_pkg::OPC_ADDR: begin
							if (sh_q[0]) begin
								st_d = opc_pkg::OPC_RD;
								tx_d = rd_cur;
								oe_d = ~rd_cur[7];
							end else begin
								st_d = opc_pkg::OPC_REG;
							end
						end
						opc_pkg::OPC_REG: begin
							ptr_d = sh_q;
							st_d  = opc_pkg::OPC_WR;
						end
						opc_pkg::OPC_WR: ptr_d = ptr_q + 8'h01;
						opc_pkg::OPC_RD: begin
							if (nack_q) begin
								st_d = opc_pkg::OPC_IDLE;
							end else begin
								ptr_d = ptr_q + 8'h01;
								tx_d  = rd_next;
								oe_d  = ~rd_next[7];
							end
						end
						opc_pkg::OPC_IDLE: oe_d = 1'b0;
					endcase
				end else begin
					cnt_d = cnt_q + 4'h1;
					if (st_q == opc_pkg::OPC_RD) begin
						tx_d = {tx_q[6:0], 1'b0};
						oe_d = ~tx_q[6];
					end
				end
			end
		end
	end

	// set/clear locations alter only the bits written as one
	always_comb begin
		c1_d = c1_q;
		c2_d = c2_q;
		if (wr_en) begin
			unique case (ptr_q)
				opc_pkg::ADR_C1_SET: c1_d = c1_q | wr_data;
				opc_pkg::ADR_C1_CLR: c1_d = c1_q & ~wr_data;
				opc_pkg::ADR_C2_SET: c2_d = c2_q | wr_data;
				opc_pkg::ADR_C2_CLR: c2_d = c2_q & ~wr_data;
				default: c1_d = c1_q;
			endcase
		end
	end

	// se0 latch: once attach is disabled, a detection is ignored and the latch clears
	always_comb begin
		attach_d = attach_q;
		if (c1_q[opc_pkg::C1_ATTACH] && flt_q[opc_pkg::PIN_SE0]) begin
			attach_d = 1'b1;
		end else if (!c1_q[opc_pkg::C1_ATTACH]) begin
			attach_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q       <= opc_pkg::OPC_IDLE;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			ptr_q      <= 8'h00;
			tx_q       <= 8'h00;
			oe_q       <= 1'b0;
			nack_q     <= 1'b0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			c1_q       <= opc_pkg::CTRL_RESET;
			c2_q       <= opc_pkg::CTRL_RESET;
			attach_q   <= 1'b0;
		end else if (clk_en) begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			ptr_q      <= ptr_d;
			tx_q       <= tx_d;
			oe_q       <= oe_d;
			nack_q     <= nack_d;
			scl_prev_q <= flt_q[opc_pkg::PIN_SCL];
			sda_prev_q <= flt_q[opc_pkg::PIN_SDA];
			c1_q       <= c1_d;
			c2_q       <= c2_d;
			attach_q   <= attach_d;
		end
	end

	// ****************************************
	// pin and line outputs
	// ****************************************
	logic [2:0] gp_out_q, gp_out_d, gp_oe_q, gp_oe_d;
	logic       rx_q, rx_d, int_n_q, int_n_d, int_oe_q, int_oe_d, dp_pu_q, dp_pu_d;
	logic       sda_out_q;

	always_comb begin
		gp_out_d = gpio_out_in;
		gp_oe_d  = gpio_oe_in;
		rx_d     = 1'b1;
		if (c1_q[opc_pkg::C1_UART_IO]) begin
			gp_out_d[opc_pkg::GP_RX] = 1'b0;
			gp_oe_d[opc_pkg::GP_RX]  = 1'b0;
			gp_out_d[opc_pkg::GP_TX] = uart2_tx_in;
			gp_oe_d[opc_pkg::GP_TX]  = 1'b1;
			rx_d = flt_q[opc_pkg::PIN_GP + opc_pkg::GP_RX];
		end
		int_oe_d = c1_q[opc_pkg::C1_INT_OUT] & c1_q[opc_pkg::C1_SUSPEND];
		int_n_d  = ~(irq_pending_in | attach_q);
		dp_pu_d  = c2_q[opc_pkg::C2_DP_PU] | attach_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gp_out_q  <= 3'h0;
			gp_oe_q   <= 3'h0;
			rx_q      <= 1'b1;
			int_n_q   <= 1'b1;
			int_oe_q  <= 1'b0;
			dp_pu_q   <= 1'b0;
			sda_out_q <= 1'b0;
		end else if (clk_en) begin
			gp_out_q  <= gp_out_d;
			gp_oe_q   <= gp_oe_d;
			rx_q      <= rx_d;
			int_n_q   <= int_n_d;
			int_oe_q  <= int_oe_d;
			dp_pu_q   <= dp_pu_d;
			sda_out_q <= 1'b0;
		end
	end

	// open drain: the data line is only ever pulled low
	assign sda_out                    = sda_out_q;
	assign sda_oe                     = oe_q;
	assign gpio_pin_out               = gp_out_q;
	assign gpio_pin_oe                = gp_oe_q;
	assign gpio_level                 = flt_q[opc_pkg::PIN_GP +: 3];
	assign uart2_rx                   = rx_q;
	assign oe_int_n_out               = int_n_q;
	assign oe_int_oe                  = int_oe_q;
	assign full_speed                 = c1_q[opc_pkg::C1_SPEED];
	assign low_power                  = c1_q[opc_pkg::C1_SUSPEND];
	assign single_ended_format_select = c1_q[opc_pkg::C1_FORMAT];
	assign uart_mode                  = c1_q[opc_pkg::C1_UART];
	assign se0_attach_flag            = attach_q;
	// the test bit is kept in c1_q for read-back only
	assign plus_line_pullup           = dp_pu_q;
	assign minus_line_pullup          = c2_q[opc_pkg::C2_DM_PU];
	assign plus_line_pulldown         = c2_q[opc_pkg::C2_DP_PD];
	assign minus_line_pulldown        = c2_q[opc_pkg::C2_DM_PD];
	assign ident_pin_ground           = c2_q[opc_pkg::C2_ID_GND];
	assign vbus_drive                 = c2_q[opc_pkg::C2_VB_DRV];
	assign vbus_discharge             = c2_q[opc_pkg::C2_VB_DIS];
	assign vbus_charge                = c2_q[opc_pkg::C2_VB_CHG];

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence set_write_s;
		clk_en && wr_en && ptr_q == opc_pkg::ADR_C1_SET;
	endsequence
	sequence clr_write_s;
		clk_en && wr_en && ptr_q == opc_pkg::ADR_C2_CLR;
	endsequence

	ctrl_set_a: assert property (set_write_s |=> ((c1_q & $past(wr_data)) == $past(wr_data)))
		else $error("set location failed to set bits");
	ctrl_clr_a: assert property (clr_write_s |=> ((c2_q & $past(wr_data)) == 8'h00))
		else $error("clear location failed to clear bits");
	ctrl_hold_a: assert property (clk_en && !wr_en |=> c1_q == $past(c1_q) && c2_q == $past(c2_q))
		else $error("control changed without a write");
	maker_read_a: assert property (ptr_q == opc_pkg::ADR_MAKER_HI |-> rd_cur == opc_pkg::MAKER_ID[15:8])
		else $error("maker high byte misread");
	part_read_a: assert property (ptr_q == opc_pkg::ADR_PART_LO |-> rd_cur == opc_pkg::PART_ID[7:0])
		else $error("part low byte misread");
	se0_attach_a: assert property (clk_en && c1_q[opc_pkg::C1_ATTACH] && flt_q[opc_pkg::PIN_SE0]
		##1 clk_en [*2] |-> plus_line_pullup && se0_attach_flag)
		else $error("se0 did not attach pull-up");
	int_pin_a: assert property (clk_en ##1 clk_en |-> oe_int_oe ==
		($past(c1_q[opc_pkg::C1_INT_OUT]) && $past(c1_q[opc_pkg::C1_SUSPEND])))
		else $error("interrupt pin enable wrong");
	uart_route_a: assert property (clk_en && c1_q[opc_pkg::C1_UART_IO] |=>
		gpio_pin_oe[opc_pkg::GP_TX] && !gpio_pin_oe[opc_pkg::GP_RX])
		else $error("second uart routing wrong");
	gpio_plain_a: assert property (clk_en && !c1_q[opc_pkg::C1_UART_IO] |=>
		gpio_pin_oe == $past(gpio_oe_in) && gpio_pin_out == $past(gpio_out_in))
		else $error("gpio not plain");
	pullup_path_a: assert property (clk_en && !attach_q |=> plus_line_pullup ==
		$past(c2_q[opc_pkg::C2_DP_PU]))
		else $error("plus pull-up mismatch");

endmodule

// [bench/opc_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// two-wire serial host, open drain
// ****************************************
module opc_host_model (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda
);
	logic nak;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nak = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask

	// data moves only while the clock is low, so no false start or stop
	task automatic wbit(input logic b);
		scl <= 1'b0;
		hold(5);
		sda <= b;
		hold(5);
		scl <= 1'b1;
		hold(10);
	endtask

	// a released line reads the pull-up unless the device pulls it low
	task automatic rbit(output logic b);
		wbit(1'b1);
		b = sda_line;
	endtask

	task automatic wbyte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--) wbit(d[i]);
		rbit(a);
		nak = nak | a;
	endtask

	// a read always ends with a not-acknowledge
	task automatic rbyte(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		wbit(1'b1);
	endtask

	task automatic start();
		wbit(1'b1);
		sda <= 1'b0;
		hold(10);
	endtask

	task automatic stop();
		wbit(1'b0);
		sda <= 1'b1;
		hold(10);
	endtask

	// only ones written matter at a set or clear location
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] adr,
			input logic [7:0] val, output logic n);
		nak = 1'b0;
		start();
		wbyte({dev, 1'b0});
		wbyte(adr);
		wbyte(val);
		stop();
		n = nak;
	endtask

	task automatic read_reg(input logic [7:0] adr, output logic [7:0] val);
		start();
		wbyte({opc_pkg::BUS_ADDR, 1'b0});
		wbyte(adr);
		start();
		wbyte({opc_pkg::BUS_ADDR, 1'b1});
		rbyte(val);
		stop();
	endtask
endmodule

// [bench/opc_regs_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module opc_regs_tb;
	logic       clk, reset_n, scl_in, host_sda, sda_in, se0_in, irq_pending_in, uart2_tx_in;
	logic       clk_en;
	logic       sda_out, sda_oe, uart2_rx, oe_int_n_out, oe_int_oe, full_speed, low_power;
	logic       single_ended_format_select, uart_mode, se0_attach_flag, plus_line_pullup;
	logic       minus_line_pullup, plus_line_pulldown, minus_line_pulldown, ident_pin_ground;
	logic       vbus_drive, vbus_discharge, vbus_charge, n;
	logic [2:0] gpio_pin_in, gpio_out_in, gpio_oe_in, gpio_pin_out, gpio_pin_oe, gpio_level;
	logic [7:0] rd, m, acc;
	int         fails, check_count;

	assign sda_in = host_sda & (sda_oe ? sda_out : 1'b1);

	opc_regs opc_regs_i (.clk, .reset_n, .clk_en, .scl_in, .sda_in, .sda_out, .sda_oe,
		.se0_in, .irq_pending_in, .gpio_pin_in, .gpio_out_in, .gpio_oe_in, .uart2_tx_in,
		.gpio_pin_out, .gpio_pin_oe, .gpio_level, .uart2_rx, .oe_int_n_out, .oe_int_oe,
		.full_speed, .low_power, .single_ended_format_select, .uart_mode, .se0_attach_flag,
		.plus_line_pullup, .minus_line_pullup, .plus_line_pulldown, .minus_line_pulldown,
		.ident_pin_ground, .vbus_drive, .vbus_discharge, .vbus_charge);

	opc_host_model opc_host_model_i (.clk, .sda_line(sda_in), .scl(scl_in), .sda(host_sda));

	// ****************************************
	// helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic hold(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		opc_host_model_i.write_reg(opc_pkg::BUS_ADDR, a, v, n);
		`CHK(n, 1'b0)
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		opc_host_model_i.read_reg(a, rd);
		`CHK(rd, e)
	endtask

	task automatic stop_test();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a hung bus must still reach the verdict
	initial begin
		hold(90000);
		fails++;
		stop_test();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		se0_in = 1'b0;
		irq_pending_in = 1'b0;
		uart2_tx_in = 1'b1;
		gpio_pin_in = 3'h7;
		gpio_out_in = 3'h0;
		gpio_oe_in = 3'h0;
		hold(12);
		reset_n <= 1'b1;
		hold(4);
		`CHK({vbus_charge, vbus_discharge, vbus_drive, ident_pin_ground}, 4'h0)
		`CHK({full_speed, low_power, single_ended_format_select, uart_mode}, 4'h0)
		rdchk(opc_pkg::ADR_C1_SET, 8'h00);
		rdchk(opc_pkg::ADR_C2_CLR, 8'h00);
		rdchk(opc_pkg::ADR_MAKER_LO, opc_pkg::MAKER_ID[7:0]);
		rdchk(opc_pkg::ADR_MAKER_HI, opc_pkg::MAKER_ID[15:8]);
		rdchk(opc_pkg::ADR_PART_LO, opc_pkg::PART_ID[7:0]);
		rdchk(opc_pkg::ADR_PART_HI, opc_pkg::PART_ID[15:8]);
		wr(opc_pkg::ADR_PART_LO, 8'hff);
		rdchk(opc_pkg::ADR_PART_LO, opc_pkg::PART_ID[7:0]);
		$display("test reset and ids done");
		// walk a one in then out; readback at the other location of the pair
		for (int r = 0; r < 2; r++) begin
			acc = 8'h00;
			for (int i = 0; i < 16; i++) begin
				m = 8'h01 << (i % 8);
				acc = (i < 8) ? (acc | m) : (acc & ~m);
				wr(8'h04 + 8'(2 * r) + 8'(i / 8), m);
				rdchk(8'h05 + 8'(2 * r) - 8'(i / 8), acc);
				if (r == 1)
					`CHK({vbus_charge, vbus_discharge, vbus_drive, ident_pin_ground, minus_line_pulldown, plus_line_pulldown, minus_line_pullup, plus_line_pullup}, acc)
				else
					`CHK({uart_mode, single_ended_format_select, low_power, full_speed}, {acc[6], acc[2:0]})
			end
		end
		$display("test set and clear done");
		wr(opc_pkg::ADR_C1_SET, 8'h20);
		`CHK(oe_int_oe, 1'b0)
		wr(opc_pkg::ADR_C1_SET, 8'h02);
		`CHK(oe_int_oe, 1'b1)
		`CHK(oe_int_n_out, 1'b1)
		irq_pending_in <= 1'b1;
		hold(3);
		`CHK(oe_int_n_out, 1'b0)
		irq_pending_in <= 1'b0;
		wr(opc_pkg::ADR_C1_CLR, 8'h22);
		`CHK(oe_int_oe, 1'b0)
		$display("test interrupt pin done");
		se0_in <= 1'b1;
		hold(8);
		`CHK({se0_attach_flag, plus_line_pullup}, 2'b00)
		se0_in <= 1'b0;
		wr(opc_pkg::ADR_C1_SET, 8'h10);
		se0_in <= 1'b1;
		hold(8);
		se0_in <= 1'b0;
		hold(8);
		`CHK({se0_attach_flag, plus_line_pullup}, 2'b11)
		`CHK(oe_int_n_out, 1'b0)
		wr(opc_pkg::ADR_C1_CLR, 8'h10);
		`CHK({se0_attach_flag, plus_line_pullup}, 2'b00)
		$display("test attach done");
		gpio_out_in <= 3'h5;
		gpio_oe_in <= 3'h1;
		uart2_tx_in <= 1'b0;
		gpio_pin_in <= 3'h6;
		hold(8);
		`CHK({gpio_pin_out, gpio_pin_oe, uart2_rx}, {3'h5, 3'h1, 1'b1})
		`CHK(gpio_level, 3'h6)
		wr(opc_pkg::ADR_C1_SET, 8'h80);
		`CHK({gpio_pin_out, gpio_pin_oe, uart2_rx}, {3'h4, 3'h2, 1'b0})
		uart2_tx_in <= 1'b1;
		hold(3);
		`CHK(gpio_pin_out, 3'h6)
		wr(opc_pkg::ADR_C1_CLR, 8'h80);
		`CHK(gpio_pin_oe, 3'h1)
		// a low enable must hold the pin drive until it returns
		clk_en <= 1'b0;
		gpio_out_in <= 3'h2;
		hold(4);
		`CHK(gpio_pin_out, 3'h5)
		clk_en <= 1'b1;
		hold(3);
		`CHK(gpio_pin_out, 3'h2)
		$display("test uart routing done");
		opc_host_model_i.write_reg(opc_pkg::BUS_ADDR ^ 7'h01, opc_pkg::ADR_C2_SET, 8'hff, n);
		`CHK(n, 1'b1)
		rdchk(opc_pkg::ADR_C2_SET, 8'h00);
		$display("test wrong address done");
		stop_test();
	end
endmodule
